// *** sasr_adc_ctrl.sv ***
// Purpose: Control and serial readout of a 12-bit successive-approximation converter
// Assumes: Select and shift clock come from the host and are sampled on REF_CLK_IN
// Notes:   Shift clock runs far slower than REF_CLK_IN so edges are found by sampling
//          A shift clock faster than about a sixth of REF_CLK_IN lets the host sample a bit on the rise before it has changed
//          Bits change a few reference cycles after the shift clock falls, so the host reads on the rise
//          Select is the only way out of a conversion; a low held past the tail only yields zeros
//          The comparator is read at the detected falling edge, one step after the trial code settled
//          Format is caught once per conversion so a pin that moves mid transfer cannot split a frame
`include "sasr_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module sasr_adc_ctrl
    import sasr_pkg::*;
(
    // Clock and reset
    input  wire logic        REF_CLK_IN,
    input  wire logic        NRST_IN,
    // Host link
    input  wire logic        SELECT_N_IN,
    input  wire logic        SHIFT_CLK_IN,
    output logic             SERIAL_OUT_OUT,
    output logic             SERIAL_OUT_OE_OUT,
    // Configuration
    input  wire logic        LSB_FIRST_IN,
    // Analog core
    input  wire logic        COMP_ABOVE_IN,
    output logic [11:0]      DAC_TRIAL_OUT,
    output logic             SAMPLE_OUT,
    output logic             POWER_DOWN_OUT,
    output logic [11:0]      RESULT_OUT
);
    sasr_regs_t r_r;
    sasr_regs_t r_nxt;
    logic       sel_n;
    logic       clk_rise;
    logic       clk_fall;

    // Synchronised link levels; only the second stage is read
    assign sel_n    = r_r.sel_sync[1];
    assign clk_rise = r_r.clk_sync[1] & ~r_r.clk_prev;
    assign clk_fall = ~r_r.clk_sync[1] & r_r.clk_prev;

    // Next state of the sequencer
    always_comb begin
        r_nxt          = r_r;
        r_nxt.sel_sync = {r_r.sel_sync[0], SELECT_N_IN};
        r_nxt.clk_sync = {r_r.clk_sync[0], SHIFT_CLK_IN};
        r_nxt.clk_prev = r_r.clk_sync[1];
        if (sel_n) begin
            // Deselect ends everything at once and floats the output
            r_nxt.state   = SASR_IDLE;
            r_nxt.dout_en = 1'b0;
            r_nxt.dout    = 1'b0;
            r_nxt.sample  = 1'b0;
            r_nxt.clk_cnt = 5'd0;
        end else begin
            case (r_r.state)
                SASR_IDLE: begin
                    // Only a fresh low after high reaches here, so a held low cannot restart
                    r_nxt.state   = SASR_ACQ;
                    r_nxt.sample  = 1'b1;
                    r_nxt.lsb_fmt = LSB_FIRST_IN;
                    r_nxt.sar     = 12'h000;
                    r_nxt.bit_idx = 4'hb;
                    r_nxt.dout_en = 1'b1;
                    r_nxt.dout    = 1'b0;
                end
                SASR_ACQ, SASR_CONV: begin
                    if (clk_fall) begin
                        r_nxt.clk_cnt = r_r.clk_cnt + 5'd1;
                        if (r_r.clk_cnt + 5'd1 == `SASR_FIRST_BIT_CLK) begin
                            r_nxt.sample = 1'b0; // Hold in the same step as the first decision
                            r_nxt.state  = SASR_CONV;
                        end
                        if (r_r.state == SASR_CONV || r_r.clk_cnt + 5'd1 == `SASR_FIRST_BIT_CLK) begin
                            // Decide one bit, latch it and drive it in the same step
                            if (r_r.clk_cnt + 5'd1 <= `SASR_MSB_LAST_CLK) begin
                                r_nxt.sar[r_r.bit_idx] = COMP_ABOVE_IN;
                                r_nxt.dout    = COMP_ABOVE_IN;
                                r_nxt.bit_idx = r_r.bit_idx - 4'd1;
                                if (r_r.clk_cnt + 5'd1 == `SASR_MSB_LAST_CLK) begin
                                    r_nxt.bit_idx = 4'd1;
                                    if (!r_r.lsb_fmt) begin
                                        r_nxt.state = SASR_TAIL;
                                    end
                                end
                            end else begin
                                // Replay LSB first from bit 1 up to the MSB
                                r_nxt.dout    = r_r.sar[r_r.bit_idx];
                                r_nxt.bit_idx = r_r.bit_idx + 4'd1;
                                if (r_r.clk_cnt + 5'd1 == `SASR_LSB_LAST_CLK) begin
                                    r_nxt.state = SASR_TAIL;
                                end
                            end
                        end
                    end
                end
                SASR_TAIL: begin
                    if (clk_fall) begin
                        r_nxt.dout = 1'b0;
                        if (r_r.clk_cnt != `SASR_CNT_MAX) begin
                            r_nxt.clk_cnt = r_r.clk_cnt + 5'd1;
                        end
                    end
                end
                default: begin
                    r_nxt.state = SASR_IDLE;
                end
            endcase
        end
    end

    // State register
    always_ff @(posedge REF_CLK_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            // Select syncs as high, so a select held low through reset starts a conversion once it has passed both synchroniser stages
            r_r <= '{
                sel_sync: 2'h3,
                clk_sync: 2'h0,
                clk_prev: 1'b0,
                state:    SASR_IDLE,
                clk_cnt:  5'h0,
                sar:      12'h000,
                bit_idx:  4'hb,
                lsb_fmt:  1'b0,
                dout:     1'b0,
                dout_en:  1'b0,
                sample:   1'b0
            };
        end else begin
            r_r <= r_nxt;
        end
    end

    // Outputs; trial code is the bits so far plus the bit under test
    assign SERIAL_OUT_OUT    = r_r.dout;
    assign SERIAL_OUT_OE_OUT = r_r.dout_en & ~sel_n;
    assign SAMPLE_OUT        = r_r.sample;
    assign POWER_DOWN_OUT    = (r_r.state == SASR_IDLE);
    assign RESULT_OUT        = r_r.sar;
    assign DAC_TRIAL_OUT     = (r_r.state == SASR_CONV || r_r.state == SASR_ACQ) && r_r.clk_cnt < `SASR_MSB_LAST_CLK
                               ? (r_r.sar | (12'h001 << r_r.bit_idx)) : r_r.sar;

    // Checks
    chk_float_deselect: assert property (@(posedge REF_CLK_IN) disable iff (!NRST_IN)
        sel_n |-> !SERIAL_OUT_OE_OUT) else $error("output driven while deselected");
    chk_power_down: assert property (@(posedge REF_CLK_IN) disable iff (!NRST_IN)
        sel_n |=> POWER_DOWN_OUT) else $error("no shutdown after deselect");
    chk_fresh_start: assert property (@(posedge REF_CLK_IN) disable iff (!NRST_IN)
        (r_r.state == SASR_IDLE && !sel_n) |=> (r_r.state == SASR_ACQ && SAMPLE_OUT)) else $error("no new sample");
    chk_hold_first: assert property (@(posedge REF_CLK_IN) disable iff (!NRST_IN)
        (r_r.state == SASR_CONV) |-> !SAMPLE_OUT) else $error("sampling during decisions");
    chk_tail_zero: assert property (@(posedge REF_CLK_IN) disable iff (!NRST_IN)
        (r_r.state == SASR_TAIL && $past(r_r.state) == SASR_TAIL && clk_fall && !sel_n) |=> !SERIAL_OUT_OUT)
        else $error("tail bit not zero");
    chk_msb_end: assert property (@(posedge REF_CLK_IN) disable iff (!NRST_IN)
        ($rose(r_r.state == SASR_TAIL) && !r_r.lsb_fmt) |-> r_r.clk_cnt == `SASR_MSB_LAST_CLK)
        else $error("msb format length wrong");
    chk_lsb_end: assert property (@(posedge REF_CLK_IN) disable iff (!NRST_IN)
        ($rose(r_r.state == SASR_TAIL) && r_r.lsb_fmt) |-> r_r.clk_cnt == `SASR_LSB_LAST_CLK)
        else $error("lsb format length wrong");
    chk_bit_echo: assert property (@(posedge REF_CLK_IN) disable iff (!NRST_IN)
        (r_r.state == SASR_CONV && clk_fall && r_r.clk_cnt < `SASR_MSB_LAST_CLK && !sel_n)
        |=> SERIAL_OUT_OUT == $past(COMP_ABOVE_IN)) else $error("decided bit not driven");
    chk_fmt_static: assert property (@(posedge REF_CLK_IN) disable iff (!NRST_IN)
        (r_r.state != SASR_IDLE && !sel_n) |=> $stable(r_r.lsb_fmt)) else $error("format changed mid transfer");

    // A held low select after the tail must never re-arm the sequencer
    chk_no_restart: assert property (@(posedge REF_CLK_IN) disable iff (!NRST_IN)
        (r_r.state == SASR_TAIL && !sel_n) |=> r_r.state == SASR_TAIL) else $error("restart without deselect");

    // While selected and busy the data line is driven
    chk_drive_select: assert property (@(posedge REF_CLK_IN) disable iff (!NRST_IN)
        (r_r.state != SASR_IDLE && !sel_n) |-> SERIAL_OUT_OE_OUT) else $error("output not driven");

    // The input is tracked for the whole acquisition
    chk_track_acq: assert property (@(posedge REF_CLK_IN) disable iff (!NRST_IN)
        (r_r.state == SASR_ACQ) |-> SAMPLE_OUT) else $error("not tracking in acquisition");

    // The first trial is the MSB alone
    chk_trial_msb: assert property (@(posedge REF_CLK_IN) disable iff (!NRST_IN)
        (r_r.state == SASR_ACQ) |-> DAC_TRIAL_OUT == 12'h800) else $error("first trial not msb");

    // The result stands through the tail
    chk_result_hold: assert property (@(posedge REF_CLK_IN) disable iff (!NRST_IN)
        (r_r.state == SASR_TAIL && !sel_n) |=> $stable(RESULT_OUT)) else $error("result moved in tail");

    // Deselect also clears the data bit so a later enable shows no stale level
    chk_zero_deselect: assert property (@(posedge REF_CLK_IN) disable iff (!NRST_IN)
        sel_n |=> !SERIAL_OUT_OUT) else $error("data left set after deselect");

    // Format is taken from the pin when the conversion starts
    chk_fmt_capture: assert property (@(posedge REF_CLK_IN) disable iff (!NRST_IN)
        (r_r.state == SASR_IDLE && !sel_n) |=> r_r.lsb_fmt == $past(LSB_FIRST_IN)) else $error("format not caught");

    // An idle converter does not track the input
    chk_idle_quiet: assert property (@(posedge REF_CLK_IN) disable iff (!NRST_IN)
        (r_r.state == SASR_IDLE) |-> !SAMPLE_OUT) else $error("sampling while shut down");

    // The replay sends stored bits from bit 1 upward
    chk_lsb_replay: assert property (@(posedge REF_CLK_IN) disable iff (!NRST_IN)
        (r_r.state == SASR_CONV && clk_fall && r_r.lsb_fmt && r_r.clk_cnt >= `SASR_MSB_LAST_CLK && !sel_n)
        |=> SERIAL_OUT_OUT == $past(r_r.sar[r_r.bit_idx])) else $error("replay bit wrong");

    // Main scenarios
    cov_msb: cover property (@(posedge REF_CLK_IN) disable iff (!NRST_IN) $rose(r_r.state == SASR_TAIL) && !r_r.lsb_fmt);
    cov_lsb: cover property (@(posedge REF_CLK_IN) disable iff (!NRST_IN) $rose(r_r.state == SASR_TAIL) && r_r.lsb_fmt);
    cov_abort: cover property (@(posedge REF_CLK_IN) disable iff (!NRST_IN) r_r.state == SASR_CONV ##1 sel_n);
    cov_tail_zero: cover property (@(posedge REF_CLK_IN) disable iff (!NRST_IN) r_r.state == SASR_TAIL && clk_fall);
    cov_held_low: cover property (@(posedge REF_CLK_IN) disable iff (!NRST_IN)
        r_r.state == SASR_TAIL && clk_fall && r_r.clk_cnt > `SASR_LSB_LAST_CLK);
endmodule : sasr_adc_ctrl
`default_nettype wire

// *** sasr_regs.svh ***
// Purpose: Constants for the serial readout of the successive-approximation converter
// Assumes: Included by the package and the converter control module
// Notes:   Counts are in shift clock periods counted from the first falling edge after select
`ifndef SASR_REGS_SVH
`define SASR_REGS_SVH
`define SASR_RES_BITS        12
`define SASR_MSB_LAST_CLK    5'd15
`define SASR_LSB_LAST_CLK    5'd26
`define SASR_FIRST_BIT_CLK   5'd4
`define SASR_CNT_MAX         5'd31
`endif

// *** sasr_pkg.sv ***
// Purpose: Types for the serial readout of the successive-approximation converter
// Assumes: Constants come from sasr_regs.svh
// Notes:   State is one packed struct per module
`include "sasr_regs.svh"
package sasr_pkg;
    typedef enum logic [1:0] {
        SASR_IDLE,
        SASR_ACQ,
        SASR_CONV,
        SASR_TAIL
    } sasr_state_t;

    typedef struct packed {
        logic [1:0] sel_sync;
        logic [1:0] clk_sync;
        logic       clk_prev;
        sasr_state_t state;
        logic [4:0] clk_cnt;
        logic [11:0] sar;
        logic [3:0] bit_idx;
        logic       lsb_fmt;
        logic       dout;
        logic       dout_en;
        logic       sample;
    } sasr_regs_t;
endpackage : sasr_pkg

// *** sasr_host_model.sv ***
// Purpose: Host model that drives select and the shift clock
// Assumes: Shift clock period 80 ns, held high outside frames
// Notes:   Data is captured on each rising shift clock edge, mid-bit
`timescale 1ns/1ps
`default_nettype none
module sasr_host_model (
    // Link
    output logic        select_n_out,
    output logic        shift_clk_out,
    input  wire logic   data_in
);
    logic [31:0] cap;
    realtime     t0;
    initial begin
        select_n_out  = 1'b1;
        shift_clk_out = 1'b1;
        cap           = '0;
    end
    // One frame of n clocks; select stays low so trailing zeros can be seen
    task automatic xfer(input int n);
        cap = '0;
        t0 = $realtime;
        select_n_out = 1'b0;
        #200;
        for (int k = 1; k <= n; k++) begin
            shift_clk_out = 1'b0;
            #40;
            shift_clk_out = 1'b1;
            cap[k] = data_in;
            #40;
        end
    endtask : xfer
    // Deselect between frames, long enough for the minimum high time
    task automatic release_sel();
        select_n_out = 1'b1;
        #200;
        // Full cycle is about 15 shift clock periods, scaled to the 80 ns bench clock
        if ($realtime - t0 < 1204.0) #(1204.0 - ($realtime - t0));
    endtask : release_sel
endmodule : sasr_host_model
`default_nettype wire

// *** sasr_adc_ctrl_tb.sv ***
// Purpose: Self-checking bench for the converter serial readout
// Assumes: Analog input is modelled as a code plus half an LSB
// Notes:   Undriven data line shows the inverse of its last value
`timescale 1ns/1ps
`default_nettype none
module sasr_adc_ctrl_tb;
    import sasr_pkg::*;
    logic        clk = 1'b0;
    logic        nrst = 1'b0;
    logic        fmt = 1'b0;
    logic        last = 1'b0;
    logic [11:0] vin = 12'h000;
    logic        dout, oe, smp, pdn, sel_n, sclk, line;
    logic [11:0] trial, res;
    int          num_errors = 0;
    int          samples_checked = 0;
    int          cyc = 0;
    logic [11:0] corner [5] = '{12'h000, 12'h001, 12'h800, 12'hffe, 12'hfff};
    always #2 clk = ~clk;
    // Released line must not look like a held bit
    assign line = oe ? dout : ~last;
    always @(posedge clk) if (oe) last <= dout;
    sasr_adc_ctrl dut (.REF_CLK_IN(clk), .NRST_IN(nrst), .SELECT_N_IN(sel_n), .SHIFT_CLK_IN(sclk),
        .SERIAL_OUT_OUT(dout), .SERIAL_OUT_OE_OUT(oe), .LSB_FIRST_IN(fmt),
        .COMP_ABOVE_IN(trial <= vin), .DAC_TRIAL_OUT(trial), .SAMPLE_OUT(smp),
        .POWER_DOWN_OUT(pdn), .RESULT_OUT(res));
    sasr_host_model host (.select_n_out(sel_n), .shift_clk_out(sclk), .data_in(line));
    // Hang guard, well above the longest expected run
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            num_errors++;
            final_report();
        end
    end
    function automatic logic exp_bit(logic [11:0] v, logic f, int k);
        if (k >= 4 && k <= 15) return v[15-k];
        if (f && k >= 16 && k <= 26) return v[k-15];
        return 1'b0;
    endfunction : exp_bit
    task automatic chk1(input string nm, input logic e, input logic s);
        samples_checked++;
        if (s !== e) begin
            num_errors++;
            $display("BAD %s exp %b got %b", nm, e, s);
        end
    endtask : chk1
    task automatic chk12(input string nm, input logic [11:0] e, input logic [11:0] s);
        samples_checked++;
        if (s !== e) begin
            num_errors++;
            $display("BAD %s exp %h got %h", nm, e, s);
        end
    endtask : chk12
    // One frame, then deselect and check shutdown
    task automatic run(input logic [11:0] v, input logic f, input int n);
        @(posedge clk);
        #1 vin = v;
        fmt = f;
        host.xfer(n);
        for (int k = 4; k <= n; k++) chk1("bit", exp_bit(v, f, k), host.cap[k]);
        if (n >= 15) chk12("result", v, res);
        if (n >= 15) chk12("trial", v, trial);
        if (n >= 4) chk1("sample", 1'b0, smp);
        chk1("awake", 1'b0, pdn);
        chk1("oe_on", 1'b1, oe);
        host.release_sel();
        chk1("oe", 1'b0, oe);
        chk1("pdn", 1'b1, pdn);
    endtask : run
    task automatic final_report();
        $display("checks %0d errors %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : final_report
    // Corners in both formats, then random frames including early aborts
    initial begin
        void'($urandom(67));
        repeat (16) @(posedge clk);
        #1 nrst = 1'b1;
        for (int i = 0; i < 10; i++) run(corner[i%5], i[0], 30);
        for (int i = 0; i < 12; i++) run(12'($urandom), 1'($urandom), 1 + $urandom % 30);
        final_report();
    end
endmodule : sasr_adc_ctrl_tb
`default_nettype wire
